// ==== hw/fwp_core.sv ====
`timescale 1ns/100ps
module fwp_core import fwp_pkg::*; #(
    parameter int STAB_CYCLES = STAB_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_slower,
    input wire logic enabled_irq,
    input wire logic wake_interrupt_pin_n,
    output logic rc_clk_sel,
    output logic osc_enable,
    output logic rc_enable,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic port_hold,
    output logic wake_irq,
    output logic core_reset
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [7:0] wcon_q; // Watchdog control register
    logic [WD_RELOAD_W-1:0] reload_q; // Reload upper bits
    logic [7:0] pwr_ctrl_q; // Power control register
    logic [7:0] scon_q; // System control register
    logic [7:0] pext_q; // Power control ext register
    logic [WD_W-1:0] wd_q; // Watchdog count
    logic wd_run_q; // Watchdog started
    logic arm_prev_q; // Arm written by the previous write
    logic wd_rst_q; // Watchdog reset pulse
    logic [31:0] stab_q; // Final reset phase counter
    logic wake_pend_q; // Wake interrupt held until taken
    fwp_pstate_e ps_q, ps_d;

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    logic aw_ok, w_ok, wr_go;
    logic [7:0] awa_q;
    logic [31:0] wd_data_q;
    logic [3:0] wstb_q;
    logic aw_have_q, w_have_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
    assign w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);
    assign wr_go = aw_ok && w_ok && !s_axi_bvalid;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    assign wr_addr = aw_have_q ? awa_q : s_axi_awaddr;
    assign wr_data = w_have_q ? wd_data_q : s_axi_wdata;
    assign wr_lane0 = w_have_q ? wstb_q[0] : s_axi_wstrb[0];

    // Hold whichever half arrives first
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_go) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awa_q <= '0;
            wd_data_q <= '0;
            wstb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wd_data_q <= s_axi_wdata;
                wstb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response, always OKAY (unmapped writes are dropped)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = 2'h0;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a[7:2] == r[7:2];
    endfunction

    logic we_wcon, we_pwr;
    assign we_wcon = wr_go && wr_lane0 && hit(wr_addr, ADDR_WDOG_CTRL);
    assign we_pwr = wr_go && wr_lane0 && hit(wr_addr, ADDR_PWR_CTRL);

    // ----------------------------------------
    // Power / oscillator sequencer
    // ----------------------------------------
    logic woke;
    logic idle_req, pd_req, stab_done;
    // Enter bits count only while their arm bit is already set in the register
    assign idle_req = we_pwr && wr_data[PC_IDLE_SET] && pwr_ctrl_q[PC_IDLE_ARM];
    assign pd_req = we_pwr && wr_data[PC_PD_SET] && pwr_ctrl_q[PC_PD_ARM];
    assign stab_done = stab_q >= 32'(STAB_CYCLES - 1);

    always_comb begin
        ps_d = ps_q;
        unique case (ps_q)
            PS_OSC_WAIT: begin
                if (!osc_slower) begin
                    ps_d = PS_SETTLE;
                end
            end
            PS_SETTLE: begin
                if (osc_slower) begin
                    ps_d = PS_OSC_WAIT;
                end else if (stab_done) begin
                    ps_d = PS_ACTIVE;
                end
            end
            PS_ACTIVE: begin
                if (osc_slower) begin
                    ps_d = PS_OSC_WAIT;
                end else if (pd_req) begin
                    ps_d = PS_PDOWN;
                end else if (idle_req) begin
                    ps_d = PS_IDLE;
                end
            end
            PS_IDLE: begin
                if (osc_slower) begin
                    ps_d = PS_OSC_WAIT;
                end else if (enabled_irq) begin
                    ps_d = PS_ACTIVE;
                end
            end
            PS_PDOWN: begin
                if (woke) begin
                    ps_d = PS_OSC_WAIT;
                end
            end
            default: ps_d = PS_OSC_WAIT;
        endcase
    end

    // Hardware reset always restarts from the RC clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ps_q <= PS_OSC_WAIT;
        end else begin
            ps_q <= ps_d;
        end
    end

    // Final reset phase length
    always_ff @(posedge aclk) begin
        if (!aresetn || ps_q != PS_SETTLE) begin
            stab_q <= '0;
        end else if (!stab_done) begin
            stab_q <= stab_q + 1'b1;
        end
    end

    // Wake came from power-down: hold the wake interrupt until taken
    logic from_wake_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            from_wake_q <= 1'b0;
            wake_pend_q <= 1'b0;
        end else begin
            if (ps_q == PS_PDOWN && woke) begin
                from_wake_q <= 1'b1;
            end else if (ps_q == PS_ACTIVE) begin
                from_wake_q <= 1'b0;
            end
            // Raised only once on nominal clock
            if (from_wake_q && ps_q == PS_SETTLE && ps_d == PS_ACTIVE) begin
                wake_pend_q <= 1'b1;
            end else if (we_pwr) begin
                wake_pend_q <= 1'b0;
            end
        end
    end
    assign wake_irq = wake_pend_q;

    fwp_wake_filt u_wake (
        .aclk(aclk),
        .aresetn(aresetn),
        .armed((ps_q == PS_PDOWN) && pext_q[PE_WAKE_EN]),
        .pin_n(wake_interrupt_pin_n),
        .woke(woke)
    );

    // Clock and reset steering
    assign rc_clk_sel = (ps_q == PS_OSC_WAIT);
    assign osc_enable = (ps_q != PS_PDOWN);
    assign rc_enable = (ps_q != PS_PDOWN);
    // After a wake the CPU keeps its state, so it must stay unclocked until settled
    assign cpu_clk_en = (ps_q == PS_ACTIVE) || (ps_q == PS_SETTLE && !from_wake_q);
    assign periph_clk_en = (ps_q == PS_ACTIVE) || (ps_q == PS_IDLE);
    assign port_hold = (ps_q == PS_PDOWN);
    // Wake from power-down keeps state, so no reset on that path
    assign core_reset = ((ps_q == PS_OSC_WAIT || ps_q == PS_SETTLE) && !from_wake_q)
                        || wd_rst_q;

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    // Software writes; enter bits are never stored and read back as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwr_ctrl_q <= '0;
            scon_q <= '0;
            pext_q <= '0;
            reload_q <= RELOAD_RST;
        end else if (wr_go && wr_lane0) begin
            if (hit(wr_addr, ADDR_PWR_CTRL)) begin
                pwr_ctrl_q <= wr_data[7:0] & ~(8'h1 << PC_IDLE_SET) & ~(8'h1 << PC_PD_SET);
            end
            if (hit(wr_addr, ADDR_SYS_CTRL)) begin
                scon_q <= wr_data[7:0];
            end
            // Wake enable accepted only while the setup gate is open
            if (hit(wr_addr, ADDR_PWR_EXT) && scon_q[SC_WAKE_GATE]) begin
                pext_q <= wr_data[7:0];
            end
            if (hit(wr_addr, ADDR_WDOG_RELOAD)) begin
                reload_q <= wr_data[WD_RELOAD_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Watchdog timer
    // ----------------------------------------
    logic cyc_tick, wd_tick, refresh, wd_count_en, wd_ovf;
    assign wd_count_en = wd_run_q && (ps_q == PS_ACTIVE);

    fwp_tick_div #(.DIV(CYCLE_DIV)) u_cyc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(wd_count_en),
        .tick(cyc_tick)
    );

    // Second stage: cycle/2 or cycle/32
    logic [4:0] pre_q;
    logic [4:0] pre_last;
    assign pre_last = 5'(fwp_rate(wcon_q[WC_RATE]) - 1);
    assign wd_tick = cyc_tick && (pre_q >= pre_last);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_q <= '0;
        end else if (cyc_tick) begin
            pre_q <= wd_tick ? '0 : pre_q + 1'b1;
        end
    end

    // Start written straight after arm in the previous write
    assign refresh = we_wcon && wr_data[WC_START] && arm_prev_q && wd_run_q;
    assign wd_ovf = wd_tick && (wd_q == {WD_W{1'b1}});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arm_prev_q <= 1'b0;
        end else if (we_wcon) begin
            arm_prev_q <= wr_data[WC_ARM] && !wr_data[WC_START];
        end else if (wr_go) begin
            arm_prev_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || wd_rst_q) begin
            wd_run_q <= 1'b0;
            wd_q <= '0;
        end else begin
            if (we_wcon && wr_data[WC_START]) begin
                wd_run_q <= 1'b1;
            end
            if (refresh || (we_wcon && wr_data[WC_START] && !wd_run_q)) begin
                wd_q <= {reload_q, {(WD_W - WD_RELOAD_W){1'b0}}};
            end else if (wd_tick) begin
                wd_q <= wd_q + 1'b1;
            end
        end
    end

    // Overflow pulse resets the core; flag survives that reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_rst_q <= 1'b0;
            wcon_q <= '0;
        end else begin
            wd_rst_q <= wd_ovf && !refresh;
            if (wd_ovf && !refresh) begin
                wcon_q[WC_RFLAG] <= 1'b1;
            end else if (we_wcon && wr_data[WC_RFLAG]) begin
                wcon_q[WC_RFLAG] <= 1'b0;
            end
            if (we_wcon) begin
                wcon_q[WC_RATE] <= wr_data[WC_RATE];
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (hit(s_axi_araddr, ADDR_WDOG_CTRL)) begin
            rd_mux = {28'h0, wcon_q[WC_RFLAG], wcon_q[WC_RATE], wd_run_q, arm_prev_q};
        end else if (hit(s_axi_araddr, ADDR_WDOG_RELOAD)) begin
            rd_mux = {25'h0, reload_q};
        end else if (hit(s_axi_araddr, ADDR_WDOG_COUNT)) begin
            rd_mux = {17'h0, wd_q};
        end else if (hit(s_axi_araddr, ADDR_PWR_CTRL)) begin
            rd_mux = {24'h0, pwr_ctrl_q};
        end else if (hit(s_axi_araddr, ADDR_SYS_CTRL)) begin
            rd_mux = {24'h0, scon_q};
        end else if (hit(s_axi_araddr, ADDR_PWR_EXT)) begin
            rd_mux = {24'h0, pext_q};
        end else if (hit(s_axi_araddr, ADDR_STATUS)) begin
            rd_mux = {27'h0, wake_pend_q, 1'b0, ps_q};
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp = 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_ovf_resets: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_ovf && !refresh |=> wd_rst_q && wcon_q[WC_RFLAG])
        else $error("overflow did not reset");
    a_idle_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        ps_q == PS_IDLE && ps_d == PS_IDLE |=> $stable(wd_q))
        else $error("watchdog moved in idle");
    a_refresh_load: assert property (@(posedge aclk) disable iff (!aresetn)
        refresh && !wd_rst_q |=> wd_q[WD_W-WD_RELOAD_W-1:0] == '0)
        else $error("refresh did not clear low bits");
    a_run_sticks: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_run_q && !wd_rst_q |=> wd_run_q)
        else $error("watchdog stopped");
    a_osc_fail: assert property (@(posedge aclk) disable iff (!aresetn)
        osc_slower && ps_q != PS_PDOWN |=> rc_clk_sel && core_reset)
        else $error("no rc clock on osc failure");
    a_pd_stops: assert property (@(posedge aclk) disable iff (!aresetn)
        pd_req && ps_q == PS_ACTIVE && !osc_slower |=> !osc_enable && !rc_enable)
        else $error("oscillators still on in power-down");
    a_idle_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        ps_q == PS_IDLE |-> !cpu_clk_en && periph_clk_en)
        else $error("idle clock gating wrong");
    a_settle_len: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ps_q == PS_SETTLE) |-> !(ps_q == PS_ACTIVE)[*8])
        else $error("settle phase too short");
    // Wake exit: oscillator good again, final delay still running
    sequence s_wake_settle;
        ps_q == PS_SETTLE && from_wake_q;
    endsequence
    a_wake_settle: assert property (@(posedge aclk) disable iff (!aresetn)
        s_wake_settle |-> !cpu_clk_en && !core_reset)
        else $error("cpu clocked during wake settle");
endmodule

// ==== hw/fwp_pkg.sv ====
package fwp_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_WDOG_CTRL = 8'h00; // Watchdog control register
    localparam logic [7:0] ADDR_WDOG_RELOAD = 8'h04; // Reload value (upper 7 bits)
    localparam logic [7:0] ADDR_WDOG_COUNT = 8'h08; // Live count, read only
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h0c; // Power control register
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h10; // System control register
    localparam logic [7:0] ADDR_PWR_EXT = 8'h14; // Power control ext register
    localparam logic [7:0] ADDR_STATUS = 8'h18; // Oscillator / mode status

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int WC_ARM = 0; // Refresh arm bit
    localparam int WC_START = 1; // Watchdog start bit
    localparam int WC_RATE = 2; // 1: cycle/32, 0: cycle/2
    localparam int WC_RFLAG = 3; // Watchdog reset flag (w1c)
    localparam int PC_IDLE_ARM = 0; // Idle arm bit
    localparam int PC_PD_ARM = 1; // Power-down arm bit
    localparam int PC_IDLE_SET = 5; // Idle enter bit
    localparam int PC_PD_SET = 6; // Power-down enter bit
    localparam int SC_WAKE_GATE = 4; // Wake setup gate bit
    localparam int PE_WAKE_EN = 7; // Pin wake-up enable bit

    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int WD_W = 15; // Watchdog counter width
    localparam int WD_RELOAD_W = 7; // Programmable upper bits
    localparam int CYCLE_DIV = 12; // Oscillator to machine cycle
    localparam int RATE_SLOW = 32; // Slow prescale
    localparam int RATE_FAST = 2; // Fast prescale
    localparam int CLK_HZ = 10_000_000; // aclk rate
    localparam int STAB_TIME_US = 1000; // Oscillator settle time, 1 ms
    localparam int STAB_CYC = STAB_TIME_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_LOW_NS = 10_000; // Least wake pin low time, 10 us
    localparam int WAKE_LOW_CYC = (WAKE_LOW_NS + 99) / 100;
    localparam logic [WD_RELOAD_W-1:0] RELOAD_RST = 7'h00; // Reset reload value

    // ----------------------------------------
    // Power / oscillator sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        PS_OSC_WAIT = 3'b000, // On RC clock, osc too slow; in reset unless woken from power-down
        PS_SETTLE = 3'b001, // Osc good, final reset phase
        PS_ACTIVE = 3'b010, // Running
        PS_IDLE = 3'b011, // CPU clock gated
        PS_PDOWN = 3'b100 // Both oscillators stopped
    } fwp_pstate_e;

    // Machine-cycle prescale select
    function automatic int fwp_rate(input logic slow);
        return slow ? RATE_SLOW : RATE_FAST;
    endfunction

endpackage

// ==== hw/fwp_tick_div.sv ====
`timescale 1ns/100ps
// Divides aclk into a one-cycle enable every DIV cycles while run is high
module fwp_tick_div import fwp_pkg::*; #(
    parameter int DIV = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    output logic tick
);
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_q; // Position inside the period

    // Count while enabled; hold while stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (run) begin
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    assign tick = run && (cnt_q == LAST);
endmodule

// ==== hw/fwp_wake_filt.sv ====
`timescale 1ns/100ps
// Reports a low wake pin held for at least LOW_CYC clocks
module fwp_wake_filt import fwp_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic armed,
    input wire logic pin_n,
    output logic woke
);
    localparam int CW = $clog2(WAKE_LOW_CYC + 1);
    localparam logic [CW-1:0] NEED = CW'(WAKE_LOW_CYC);
    logic [CW-1:0] low_q; // Consecutive low cycles

    // Restart on any high level or when not armed
    always_ff @(posedge aclk) begin
        if (!aresetn || !armed || pin_n) begin
            low_q <= '0;
        end else if (low_q != NEED) begin
            low_q <= low_q + 1'b1;
        end
    end

    assign woke = armed && (low_q == NEED);
endmodule

// ==== sim/tb_failsafe_watchdog_power_control.sv ====
`timescale 1ns/100ps
module tb_failsafe_watchdog_power_control;
    import fwp_pkg::*;
    // ----------------------------------------
    // Stimulus, bus and observed signals
    // ----------------------------------------
    localparam int STAB = 16; // Shortened settle count
    logic aclk = 0, aresetn = 0, osc_slower = 1, enabled_irq = 0, wake_interrupt_pin_n = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, e;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rc_clk_sel, osc_enable, rc_enable, cpu_clk_en, periph_clk_en;
    logic port_hold, wake_irq, core_reset;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] r;
    int n_errors = 0, checked = 0, n;
    always #50 aclk = ~aclk; // 10 MHz
    fwp_core #(.STAB_CYCLES(STAB)) fwp_core_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_slower,
        .enabled_irq, .wake_interrupt_pin_n, .rc_clk_sel, .osc_enable, .rc_enable, .cpu_clk_en,
        .periph_clk_en, .port_hold, .wake_irq, .core_reset);
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Expected live count right after a reload
    function automatic logic [14:0] exp_count(input logic [6:0] rl);
        return {rl, 8'h00};
    endfunction
    // ----------------------------------------
    // AXI4-Lite master tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (k = 0; k < 50; k++) begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tb) break;
        end
        s_axi_bready <= 0;
        if (k == 50) begin
            n_errors++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic ta, tr;
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (k = 0; k < 50; k++) begin
            @(negedge aclk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            v = s_axi_rdata;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            if (tr) break;
        end
        s_axi_rready <= 0;
        if (k == 50) begin
            n_errors++;
            print_verdict();
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h4e2d));
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        // Power-on: crystal not yet running
        repeat (5) @(negedge aclk);
        check({rc_clk_sel, core_reset}, 2'b11);
        @(posedge aclk);
        osc_slower <= 0;
        for (n = 0; n < 100 && core_reset !== 1'b0; n++) @(negedge aclk);
        check(n >= STAB && n <= STAB + 3, 1);
        rd(ADDR_STATUS, d);
        check(d[2:0], 3'd2);
        $display("test power-on done");
        // Watchdog load, refresh order, rate
        r = 7'($urandom);
        wr(ADDR_WDOG_RELOAD, {1'b0, r});
        wr(ADDR_WDOG_CTRL, 8'h02);
        rd(ADDR_WDOG_COUNT, d);
        check(d[14:8], r);
        repeat (600) @(posedge aclk);
        wr(ADDR_WDOG_CTRL, 8'h01);
        wr(ADDR_WDOG_RELOAD, {1'b0, r});
        wr(ADDR_WDOG_CTRL, 8'h02);
        wr(ADDR_WDOG_CTRL, 8'h00);
        rd(ADDR_WDOG_COUNT, d);
        check(d[7:0] >= 8'd20 && d[7:0] <= 8'd30, 1);
        rd(ADDR_WDOG_CTRL, d);
        check(d[1], 1'b1);
        wr(ADDR_WDOG_CTRL, 8'h01);
        wr(ADDR_WDOG_CTRL, 8'h02);
        rd(ADDR_WDOG_COUNT, d);
        check(d[14:0] >= exp_count(r) && d[14:0] <= exp_count(r) + 15'd1, 1);
        $display("test watchdog refresh done");
        // Overflow with highest reload
        wr(ADDR_WDOG_RELOAD, 8'h7f);
        wr(ADDR_WDOG_CTRL, 8'h01);
        wr(ADDR_WDOG_CTRL, 8'h02);
        for (n = 0; n < 7000 && core_reset !== 1'b1; n++) @(negedge aclk);
        check(n > 6000 && n < 6200, 1);
        rd(ADDR_WDOG_CTRL, d);
        check(d[3], 1'b1);
        wr(ADDR_WDOG_CTRL, 8'h08);
        rd(ADDR_WDOG_CTRL, d);
        check(d[3], 1'b0);
        $display("test overflow done");
        // Idle entry, frozen count, interrupt exit
        wr(ADDR_WDOG_RELOAD, 8'h00);
        wr(ADDR_WDOG_CTRL, 8'h02);
        wr(ADDR_PWR_CTRL, 8'h01);
        wr(ADDR_PWR_CTRL, 8'h21);
        rd(ADDR_STATUS, d);
        check({d[2:0], cpu_clk_en, periph_clk_en}, {3'd3, 2'b01});
        rd(ADDR_WDOG_COUNT, e);
        repeat (100) @(posedge aclk);
        rd(ADDR_WDOG_COUNT, d);
        check(d, e);
        enabled_irq <= 1;
        repeat (3) @(posedge aclk);
        enabled_irq <= 0;
        rd(ADDR_STATUS, d);
        check({d[2:0], cpu_clk_en}, {3'd2, 1'b1});
        $display("test idle done");
        // Power-down with pin wake
        r = 7'($urandom);
        wr(ADDR_WDOG_RELOAD, {1'b0, r});
        wr(ADDR_SYS_CTRL, 8'h10);
        wr(ADDR_PWR_EXT, 8'h80);
        wr(ADDR_SYS_CTRL, 8'h00);
        wr(ADDR_PWR_CTRL, 8'h02);
        wr(ADDR_PWR_CTRL, 8'h42);
        rd(ADDR_STATUS, d);
        check({d[2:0], osc_enable, rc_enable, port_hold}, {3'd4, 3'b001});
        wake_interrupt_pin_n <= 0;
        repeat (50) @(posedge aclk);
        wake_interrupt_pin_n <= 1;
        repeat (5) @(negedge aclk);
        check(port_hold, 1'b1);
        @(posedge aclk);
        wake_interrupt_pin_n <= 0;
        for (n = 0; n < 200 && osc_enable !== 1'b1; n++) @(negedge aclk);
        check(n >= 95 && n < 110, 1);
        @(posedge aclk);
        wake_interrupt_pin_n <= 1;
        for (n = 0; n < 100 && cpu_clk_en !== 1'b1; n++) @(negedge aclk);
        check(n >= STAB && n < 100, 1);
        rd(ADDR_STATUS, d);
        check({d[4], wake_irq}, 2'b11);
        rd(ADDR_WDOG_RELOAD, d);
        check(d[6:0], r);
        $display("test power-down done");
        // Oscillator failure, then hardware reset
        osc_slower <= 1;
        repeat (3) @(negedge aclk);
        check({rc_clk_sel, core_reset}, 2'b11);
        @(posedge aclk);
        osc_slower <= 0;
        for (n = 0; n < 100 && core_reset !== 1'b0; n++) @(negedge aclk);
        check(n >= STAB - 3 && n <= STAB + 3, 1);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        rd(ADDR_WDOG_RELOAD, d);
        check(d[6:0], RELOAD_RST);
        rd(ADDR_PWR_EXT, d);
        check(d, 32'h0);
        $display("test failure and reset done");
        print_verdict();
    end
endmodule
